// File: dv/bas_asserts.sv
// checker for the burst address sequencer, watching only its ports
// assumes one clock domain and is bound onto bas_top below
`timescale 1ns/10ps
module bas_asserts
  import bas_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int PEND_W = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link and configuration
  input wire logic link_cs_n,
  input wire logic link_ck,
  input wire logic [7:0] link_dq,
  input wire logic cfg_load,
  input wire logic [2:0] burst_sequence_field,
  // stream and status
  input wire logic addr_valid,
  input wire logic [ADDR_W-1:0] addr_word,
  input wire logic addr_ready,
  input wire logic burst_active,
  input wire logic [2:0] cfg_current
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic have_r, have_nxt;
  logic [ADDR_W-1:0] last_r, last_nxt;
  // last word taken in the current frame; forgotten while chip select is high
  always_comb
  begin
    acc = addr_valid && addr_ready;
    have_nxt = link_cs_n ? 1'h0 : (acc ? 1'h1 : have_r);
    last_nxt = acc ? addr_word : last_r;
  end
  always_ff @(posedge clk_sys)
  begin
    have_r <= sys_rst ? 1'h0 : have_nxt;
    last_r <= last_nxt;
  end
  sequence cs_idle_s;
    link_cs_n [*4];
  endsequence
  sequence cs_start_s;
    $fell(link_cs_n) && !addr_valid;
  endsequence
  AST_RST: assert property ($fell(sys_rst) |-> !addr_valid && !burst_active && cfg_current == 3'h7)
    else $error("outputs not at reset values");
  AST_CFG_LOAD: assert property (cfg_load |=> cfg_current == $past(burst_sequence_field))
    else $error("configuration not loaded");
  AST_CFG_HOLD: assert property (!cfg_load |=> $stable(cfg_current))
    else $error("configuration changed without load");
  AST_STANDS: assert property (addr_valid && !addr_ready |=> addr_valid && $stable(addr_word))
    else $error("offered word lost while stalled");
  AST_STEP: assert property (acc && have_r |-> addr_word == last_r + 1 || addr_word[ADDR_W-1:6] == last_r[ADDR_W-1:6]
    || (addr_word[2:0] == 3'h0 && addr_word - last_r <= 32'h40))
    else $error("word step outside group or linear order");
  AST_NO_IDLE: assert property ($rose(addr_valid) |-> burst_active)
    else $error("word offered outside a burst");
  AST_CS_IDLE: assert property (cs_idle_s |=> !burst_active)
    else $error("burst still active with chip select high");
  AST_CA_QUIET: assert property (cs_start_s |=> !addr_valid [*8])
    else $error("word offered during command-address");
endmodule

bind bas_top bas_asserts #(.ADDR_W(ADDR_W), .PEND_W(PEND_W)) u_chk (.clk_sys, .sys_rst, .link_cs_n, .link_ck,
  .link_dq, .cfg_load, .burst_sequence_field, .addr_valid, .addr_word, .addr_ready, .burst_active, .cfg_current);

// File: dv/bas_host.sv
// host model: chip select, link clock and command-address bytes
// assumes the bench calls frame and waits for it; clock stands low between frames
`timescale 1ns/10ps
module bas_host
(
  // link pins
  output logic link_cs_n,
  output logic link_ck,
  output logic [7:0] link_dq
);
  localparam time HALF = 80ns;
  // idle pins
  initial
  begin
    link_cs_n = 1'h1;
    link_ck = 1'h0;
    link_dq = 8'hA5;
  end
  // six bytes on both clock edges, then n rising edges, then chip select high
  task automatic frame(input logic [47:0] ca, input int n);
    #7ns;
    link_cs_n = 1'h0;
    #HALF;
    for (int i = 5; i >= 0; i--)
    begin
      link_dq = ca[i*8 +: 8];
      #(HALF / 2);
      link_ck = ~link_ck;
      #(HALF / 2);
    end
    link_dq = ~link_dq; // released bus shows no stale byte
    for (int i = 0; i < n; i++)
    begin
      link_ck = 1'h1;
      #HALF;
      link_ck = 1'h0;
      #HALF;
    end
    link_cs_n = 1'h1;
  endtask
endmodule

// File: dv/burst_address_sequencer_tb.sv
// bench: host model drives frames, accepted words are collected and compared
// assumes bas_top, bas_host and the bound checker are compiled first
`timescale 1ns/10ps
module burst_address_sequencer_tb;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic cfg_load = 1'h0;
  logic [2:0] fld = 3'h0;
  logic addr_ready = 1'h1;
  logic stall = 1'h0;
  logic link_cs_n, link_ck, addr_valid, burst_active;
  logic [7:0] link_dq;
  logic [31:0] addr_word;
  logic [2:0] cfg_current;
  logic [31:0] got[$];
  int bad_count = 0;
  int comparisons = 0;
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  bas_host host (.link_cs_n, .link_ck, .link_dq);
  bas_top dut (.clk_sys, .sys_rst, .link_cs_n, .link_ck, .link_dq, .cfg_load, .burst_sequence_field(fld),
    .addr_valid, .addr_word, .addr_ready, .burst_active, .cfg_current);
  // drain side ready, stalled on request
  always @(negedge clk_sys) addr_ready <= !stall;
  // collect accepted words
  always @(posedge clk_sys) if (addr_valid === 1'h1 && addr_ready) got.push_back(addr_word);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // group size in words for a length code
  function automatic logic [31:0] gw(logic [2:0] c);
    return (c[1:0] == 2'h0) ? 32'h40 : (c[1:0] == 2'h1) ? 32'h20 : (c[1:0] == 2'h2) ? 32'h08 : 32'h10;
  endfunction
  // expected i-th word of a burst
  function automatic logic [31:0] exp_word(logic [31:0] s, logic lin, logic [2:0] c, int i);
    logic [31:0] g;
    logic [31:0] base;
    g = gw(c);
    base = s & ~(g - 32'h1);
    if (lin)
      return s + i;
    if (!c[2] && i >= g)
      return base + i;
    return base + ((s - base + i) % g);
  endfunction
  task automatic load_cfg(input logic [2:0] c);
    @(negedge clk_sys);
    cfg_load = 1'h1;
    fld = c;
    @(negedge clk_sys);
    cfg_load = 1'h0;
    check(cfg_current, c, "config");
  endtask
  task automatic burst(input logic [2:0] c, input logic lin, input logic [31:0] s, input int n);
    got.delete();
    host.frame({2'h0, lin, s[31:3], 13'h0000, s[2:0]}, n);
    for (int k = 0; k < 50 && burst_active !== 1'h0; k++)
      @(negedge clk_sys);
    repeat (6) @(negedge clk_sys);
    check(got.size(), n, "word count");
    check(addr_valid, 1'h0, "buffer drained");
    for (int i = 0; i < n && i < got.size(); i++)
      check(got[i], exp_word(s, lin, c, i), "word");
  endtask
  task automatic t_reset();
    check(cfg_current, 3'h7, "reset config");
    check(addr_valid, 1'h0, "reset valid");
    check(burst_active, 1'h0, "reset active");
  endtask
  // every sequence setting, one group and a bit more
  task automatic t_table();
    logic [31:0] st[8] = '{32'h03, 32'h03, 32'h0C, 32'h0A, 32'h03, 32'h2E, 32'h0C, 32'h1E};
    for (int c = 0; c < 8; c++)
    begin
      load_cfg(c[2:0]);
      burst(c[2:0], 1'h0, st[c], gw(c[2:0]) + 4);
    end
  endtask
  task automatic t_linear();
    load_cfg(3'h0);
    burst(3'h0, 1'h1, 32'h00000FFE, 6);
  endtask
  // receiver stalls mid-burst, no word lost
  task automatic t_stall();
    load_cfg(3'h5);
    fork
      burst(3'h5, 1'h1, 32'h0ABCDEF0, 20);
      begin
        repeat (40) @(negedge clk_sys);
        check(burst_active, 1'h1, "active mid-burst");
        stall = 1'h1;
        repeat (40) @(negedge clk_sys);
        stall = 1'h0;
      end
    join
  endtask
  // reset in mid-run restores the default setting
  task automatic t_reset_default();
    load_cfg(3'h2);
    sys_rst = 1'h1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'h0;
    repeat (3) @(negedge clk_sys);
    check(cfg_current, 3'h7, "default config");
    burst(3'h7, 1'h0, 32'h1E, 20);
  endtask
  initial
  begin
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'h0;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_table();
    t_linear();
    t_stall();
    t_reset_default();
    summarize();
  end
  // watchdog
  initial
  begin
    #300us;
    bad_count++;
    summarize();
  end
endmodule

// File: src/bas_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes the drain side may stall for any time
`timescale 1ns/10ps
module bas_buf
  import bas_pkg::*;
#(
  parameter int W = 32
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  logic hv_r;
  logic hv_nxt;
  logic sv_r;
  logic sv_nxt;
  logic [W-1:0] head_r;
  logic [W-1:0] head_nxt;
  logic [W-1:0] spare_r;
  logic [W-1:0] spare_nxt;
  logic pop;
  logic push;

  // head entry drives the output, spare catches a word during a stall
  always_comb
  begin
    pop = hv_r & out_ready;
    push = in_valid & ~sv_r;
    hv_nxt = hv_r;
    sv_nxt = sv_r;
    head_nxt = head_r;
    spare_nxt = spare_r;
    if (pop)
    begin
      if (sv_r)
      begin
        head_nxt = spare_r;
        sv_nxt = 1'b0;
      end
      else if (push)
        head_nxt = in_data;
      else
        hv_nxt = 1'b0;
    end
    else if (push)
    begin
      if (!hv_r)
      begin
        head_nxt = in_data;
        hv_nxt = 1'b1;
      end
      else
      begin
        spare_nxt = in_data;
        sv_nxt = 1'b1;
      end
    end
  end

  // register the entries
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hv_r <= 1'b0;
      sv_r <= 1'b0;
      head_r <= '0;
      spare_r <= '0;
    end
    else
    begin
      hv_r <= hv_nxt;
      sv_r <= sv_nxt;
      head_r <= head_nxt;
      spare_r <= spare_nxt;
    end
  end

  assign in_ready = ~sv_r;
  assign out_valid = hv_r;
  assign out_data = head_r;

endmodule

// File: src/bas_pkg.sv
// shared constants and types for the burst address sequencer
// assumes the sequencer runs on one system clock and samples all link pins
package bas_pkg;

  // command-address phase layout
  localparam int CA_BYTES = 6;
  localparam int CA_W = 48;
  localparam int CA_TYPE_BIT = 45;
  localparam int CA_UP_HI = 44;
  localparam int CA_UP_LO = 16;
  localparam int CA_LOW_HI = 2;
  localparam logic [2:0] CA_CNT_LAST = 3'h5;

  // burst length field encodings
  localparam logic [1:0] LEN_128 = 2'h0;
  localparam logic [1:0] LEN_64 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h2;
  localparam logic [1:0] LEN_32 = 2'h3;

  // group sizes in 16-bit words
  localparam logic [6:0] GW_128 = 7'h40;
  localparam logic [6:0] GW_64 = 7'h20;
  localparam logic [6:0] GW_16 = 7'h08;
  localparam logic [6:0] GW_32 = 7'h10;

  // configuration reset value: legacy wrap, 32-byte group
  localparam logic CFG_LEGACY_RST = 1'b1;
  localparam logic [1:0] CFG_LEN_RST = LEN_32;
  localparam int SEQ_HYB_BIT = 2;

  // link clock timing
  localparam int SYS_PERIOD_NS = 20;
  localparam int CK_PERIOD_NS = 160;
  localparam int CK_HALF_CYC = (CK_PERIOD_NS / 2) / SYS_PERIOD_NS;
  localparam int CK_HALF_MIN = 2;

  // latched burst configuration
  typedef struct packed
  {
    logic legacy;
    logic [1:0] len;
  } bas_cfg_t;

  // link pins as sampled
  typedef struct packed
  {
    logic cs_n;
    logic ck;
    logic [7:0] dq;
  } bas_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CA, ST_WRAP, ST_LIN} bas_state_t;

endpackage

// File: src/bas_sync.sv
// two-flop synchroniser for the link pins
// assumes the pins are asynchronous to clk_sys
`timescale 1ns/10ps
module bas_sync
  import bas_pkg::*;
#(
  parameter int W = 10
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // asynchronous side
  input wire logic [W-1:0] async_in,
  // synchronous side
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // first flop feeds only the second
  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // register both stages, idle level is all ones (chip select high)
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_r <= '1;
      sync_r <= '1;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

// File: src/bas_top.sv
// burst address sequencer: takes the command-address from the link pins and
// streams one word address per rising link clock through a two-entry buffer
// assumes link pins are asynchronous and the link clock is far slower than clk_sys
`timescale 1ns/10ps
module bas_top
  import bas_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int PEND_W = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link pins
  input wire logic link_cs_n,
  input wire logic link_ck,
  input wire logic [7:0] link_dq,
  // configuration load
  input wire logic cfg_load,
  input wire logic [2:0] burst_sequence_field,
  // address stream
  output logic addr_valid,
  output logic [ADDR_W-1:0] addr_word,
  input wire logic addr_ready,
  // status
  output logic burst_active,
  output logic [2:0] cfg_current
);

  // elaboration checks
  if (ADDR_W != CA_UP_HI - CA_UP_LO + 1 + CA_LOW_HI + 1)
    $error("ADDR_W must match the command-address word address width");
  if (PEND_W < 2)
    $error("PEND_W must be at least 2");
  if (CK_HALF_CYC < CK_HALF_MIN)
    $error("link clock too fast for sampling");

  bas_pins_t pins_raw;
  bas_pins_t pins_s;
  logic ck_d_r;
  logic ck_d_nxt;
  logic ck_rise;
  logic ck_edge;
  logic cs_low;

  // synchronise the link pins
  assign pins_raw = '{cs_n: link_cs_n, ck: link_ck, dq: link_dq};

  bas_sync #(.W($bits(bas_pins_t))) u_sync
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // link clock edge detection on the synchronised level
  always_comb
  begin
    ck_d_nxt = pins_s.ck;
    ck_edge = pins_s.ck ^ ck_d_r;
    ck_rise = pins_s.ck & ~ck_d_r;
    cs_low = ~pins_s.cs_n;
  end

  // register the previous link clock level
  // the synchroniser resets to ones, so this flop does too
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ck_d_r <= 1'b1; // no false rise right after reset
    else
      ck_d_r <= ck_d_nxt;
  end

  // configuration word
  bas_cfg_t cfg_r;
  bas_cfg_t cfg_nxt;

  // take a new setting on the load pulse, hold it otherwise
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (cfg_load)
    begin
      cfg_nxt.legacy = burst_sequence_field[SEQ_HYB_BIT];
      cfg_nxt.len = burst_sequence_field[1:0];
    end
  end

  // register the setting; reset gives legacy wrap over a 32-byte group
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg_r.legacy <= CFG_LEGACY_RST;
      cfg_r.len <= CFG_LEN_RST;
    end
    else
      cfg_r <= cfg_nxt;
  end

  // sequencer state
  bas_state_t state_r;
  bas_state_t state_nxt;
  logic [CA_W-1:0] ca_r;
  logic [CA_W-1:0] ca_nxt;
  logic [2:0] ca_cnt_r;
  logic [2:0] ca_cnt_nxt;
  bas_cfg_t bcfg_r;
  bas_cfg_t bcfg_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [6:0] wcnt_r;
  logic [6:0] wcnt_nxt;
  logic [PEND_W-1:0] pend_r;
  logic [PEND_W-1:0] pend_nxt;
  logic [6:0] gw;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] wrap_next;
  logic [ADDR_W-1:0] addr_plus;
  logic [ADDR_W-1:0] ca_addr;
  logic emit;
  logic buf_ready;
  logic in_burst;

  // group size in words from the latched length field
  always_comb
  begin
    case (bcfg_r.len)
      LEN_128: gw = GW_128;
      LEN_64: gw = GW_64;
      LEN_16: gw = GW_16;
      default: gw = GW_32;
    endcase
    mask = ADDR_W'(gw) - ADDR_W'(1);
    base = addr_r & ~mask;
    addr_plus = addr_r + ADDR_W'(1);
    wrap_next = base | (addr_plus & mask);
    ca_addr = {ca_r[CA_UP_HI:CA_UP_LO], ca_r[CA_LOW_HI:0]};
  end

  // next-state logic for the burst walk
  always_comb
  begin
    in_burst = (state_r == ST_WRAP) || (state_r == ST_LIN);
    emit = in_burst && (pend_r != '0);
    state_nxt = state_r;
    ca_nxt = ca_r;
    ca_cnt_nxt = ca_cnt_r;
    bcfg_nxt = bcfg_r;
    addr_nxt = addr_r;
    wcnt_nxt = wcnt_r;
    pend_nxt = pend_r;
    if (!cs_low)
    begin
      state_nxt = ST_IDLE;
      pend_nxt = '0;
      ca_cnt_nxt = '0;
      wcnt_nxt = '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          state_nxt = ST_CA;
          ca_cnt_nxt = '0;
        end
        ST_CA:
        begin
          if (ck_edge)
          begin
            ca_nxt = {ca_r[CA_W-9:0], pins_s.dq};
            ca_cnt_nxt = ca_cnt_r + 3'h1;
            if (ca_cnt_r == CA_CNT_LAST)
            begin
              // latch start, type and setting at end of command-address
              bcfg_nxt = cfg_r;
              addr_nxt = {ca_r[CA_UP_HI-8:CA_UP_LO-8], pins_s.dq[CA_LOW_HI:0]};
              wcnt_nxt = '0;
              if (ca_r[CA_TYPE_BIT-8])
                state_nxt = ST_LIN;
              else
                state_nxt = ST_WRAP;
            end
          end
        end
        ST_WRAP:
        begin
          if (emit && buf_ready)
          begin
            if ((wcnt_r == gw - 7'h1) && !bcfg_r.legacy)
            begin
              addr_nxt = base + ADDR_W'(gw);
              state_nxt = ST_LIN;
            end
            else
            begin
              addr_nxt = wrap_next;
              wcnt_nxt = (wcnt_r == gw - 7'h1) ? 7'h0 : wcnt_r + 7'h1;
            end
          end
        end
        default:
        begin
          if (emit && buf_ready)
            addr_nxt = addr_plus;
        end
      endcase
      // one word owed per rising link clock once the burst runs
      if (in_burst)
      begin
        if (ck_rise && !(emit && buf_ready) && (pend_r != '1))
          pend_nxt = pend_r + PEND_W'(1);
        else if (!ck_rise && emit && buf_ready)
          pend_nxt = pend_r - PEND_W'(1);
      end
    end
  end

  // register the sequencer state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      ca_r <= '0;
      ca_cnt_r <= '0;
      bcfg_r <= '0;
      addr_r <= '0;
      wcnt_r <= '0;
      pend_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      ca_r <= ca_nxt;
      ca_cnt_r <= ca_cnt_nxt;
      bcfg_r <= bcfg_nxt;
      addr_r <= addr_nxt;
      wcnt_r <= wcnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  // buffer toward the array side
  bas_buf #(.W(ADDR_W)) u_buf
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(emit),
    .in_data(addr_r),
    .in_ready(buf_ready),
    .out_valid(addr_valid),
    .out_data(addr_word),
    .out_ready(addr_ready)
  );

  // status flags
  logic active_r;
  logic active_nxt;

  // burst flag follows the walk one cycle late
  always_comb
  begin
    active_nxt = in_burst;
  end

  // register the burst flag so the output comes from a flop
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      active_r <= 1'b0;
    else
      active_r <= active_nxt;
  end

  assign burst_active = active_r;
  assign cfg_current = {cfg_r.legacy, cfg_r.len};

endmodule
